// [logic/exs_cfg.svh]
// Purpose: Constants for the exception sequencer
// Assumes: Included by bare name
// Notes:   Vector numbers, register offsets, reset values
`ifndef EXS_CFG_SVH
`define EXS_CFG_SVH
`define EXS_AW        24
`define EXS_DW        16
`define EXS_VNW       7
`define EXS_VN_RESET  7'h00
`define EXS_VN_DIRECT 7'h06
`define EXS_VN_NMI    7'h07
`define EXS_VN_TRAP   7'h08
`define EXS_VN_IRQ    7'h10
`define EXS_VN_INT_LO 7'h18
`define EXS_VN_INT_HI 7'h6f
`define EXS_RAW       2
`define EXS_REG_SYS   2'h0
`define EXS_REG_MSTOP 2'h1
`define EXS_REG_CCR   2'h2
`define EXS_REG_STAT  2'h3
`define EXS_MSTOP_RST 16'hffff
`define EXS_INTM_M1   2'h1
`define EXS_CCR_I     7
`define EXS_CCR_UI    6
`define EXS_STRAP_ADV 1'b0
`endif

// [logic/exs_pkg.sv]
// Purpose: Types shared by the exception sequencer
// Assumes: Nothing
// Notes:   State and exception-kind enumerations
package exs_pkg;
  typedef enum logic [2:0] {
    S_HOLD, S_RVEC, S_LOAD, S_RUN, S_PUSH_PC, S_PUSH_CCR, S_VEC
  } exs_state_t;
  typedef enum logic [1:0] {K_RESET, K_INT, K_DIRECT, K_TRAP} exs_kind_t;
endpackage : exs_pkg

// [logic/exs_sequencer.sv]
// Purpose: Exception sequencer: reset, interrupt, direct transition, trap
// Assumes: Pipeline stalls while cpu_halt is high; memory acks in-clock
// Notes:   Stack pointer lives in the pipeline; pushes are tagged writes
// Behaviour
// - Mode 2: advanced single-chip, 16-Mbyte space, on-chip ROM on.
// - Mode 3: normal single-chip, 64-Kbyte space, 56 kbyte usable, ROM on.
// - Priority is reset, interrupt, direct transition, trap; pending ones go in order.
// - Reset handling starts on reset pin rising or watchdog overflow.
// - Interrupts are taken only at instruction or exception sequence end.
// - No interrupt detection after flag-logic or control-load insns, or reset handling.
// - Direct transition handling starts when sleep causes a direct transition.
// - Traps are always taken in program execution, whatever the mask.
// - Vector entry is number times 2 (normal) or 4 (advanced); reset at 0.
// - Vectors: reset 0, direct 6, NMI 7, traps 8-11, lines 16-23, internal 24-111.
// - While reset pin is low all processing halts in reset state.
// - Any reset initialises CPU state and all peripheral registers.
// - Reset sets interrupt mask, loads reset vector into PC, then runs.
// - All interrupts including NMI blocked until first instruction completes.
// - After reset all peripherals are in module stop, registers not accessible.
// - Interrupt pushes PC and CONDITION_CODE_REGISTER, fetches vector into PC, resumes there.
// - Sources are NMI, request lines, keyboard, wakeup, peripherals; NMI highest.
// - Trap pushes PC and CONDITION_CODE_REGISTER, fetches selected vector into PC, continues.
// - Trap selects one of four vectors by a 0-3 field in the instruction.
// - After trap I is set; UI set in mode 1, kept in mode 0.
// - Interrupt control mode comes from interrupt_mode_sel in system_control_reg.
`timescale 1ns/1ps
`include "exs_cfg.svh"
module exs_sequencer (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                external_reset_pin_n,
  input  wire logic                mode_sel_pin,
  input  wire logic                wdt_overflow,
  input  wire logic                nmi_req,
  input  wire logic [7:0]          irq_req,
  input  wire logic                int_req,
  input  wire logic [`EXS_VNW-1:0] int_vec,
  input  wire logic                insn_done,
  input  wire logic                insn_no_irq,
  input  wire logic                sleep_direct,
  input  wire logic                trap_exec,
  input  wire logic [1:0]          trap_num,
  input  wire logic [`EXS_AW-1:0]  pc_in,
  input  wire logic [7:0]          ccr_in,
  input  wire logic                mem_ack,
  input  wire logic [31:0]         mem_rdata,
  input  wire logic [`EXS_RAW-1:0] reg_addr,
  input  wire logic [`EXS_DW-1:0]  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [`EXS_DW-1:0]       reg_rdata,
  output logic                     cpu_halt,
  output logic                     periph_rst,
  output logic                     pc_load,
  output logic [`EXS_AW-1:0]       pc_value,
  output logic                     mem_req,
  output logic                     mem_push,
  output logic [`EXS_AW-1:0]       mem_addr,
  output logic [`EXS_AW-1:0]       mem_wdata,
  output logic                     int_ack,
  output logic [`EXS_VNW-1:0]      ack_vec,
  output logic                     i_mask,
  output logic                     ui_mask,
  output logic [`EXS_DW-1:0]       mstop,
  output logic                     adv_mode
);
  exs_pkg::exs_state_t state_r;
  exs_pkg::exs_kind_t  kind_r;
  logic                res_s1_r, res_s2_r, mode_s1_r, mode_s2_r;
  logic                int_rst, adv_r, blk_r, i_r, ui_r;
  logic [1:0]          intm_r;
  logic [`EXS_DW-1:0]  mstop_r, rdata_r;
  logic [`EXS_VNW-1:0] num_r, int_num, tnum_r, ack_vec_r;
  logic                trap_pend_r, dt_pend_r, int_hit, int_go, go;
  logic                st_run, st_load, bnd, mode1;
  logic                req_r, push_r, pc_load_r, halt_r, prst_r, int_ack_r;
  logic [`EXS_AW-1:0]  addr_r, wdata_r, pc_r, ret_pc, vec_pc;
  exs_pkg::exs_kind_t  kind_nxt;
  logic [`EXS_VNW-1:0] num_nxt;

  exs_vec_if vi ();
  assign vi.num = num_r;
  assign vi.adv = adv_r;
  exs_vec_gen u_vec (.vi(vi));

  // Pins are asynchronous: two flops before use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_s1_r <= 1'b0;
      res_s2_r <= 1'b0;
    end else begin
      res_s1_r <= external_reset_pin_n;
      res_s2_r <= res_s1_r;
    end
  end

  // Strap sync runs through reset, so the strap is settled before reset ends
  always_ff @(posedge sys_clk) begin
    mode_s1_r <= mode_sel_pin;
    mode_s2_r <= mode_s1_r;
  end

  // Pin low or watchdog overflow holds everything but the pin and strap sync flops in reset
  assign int_rst = rst | ~res_s2_r | wdt_overflow;
  assign st_run  = (state_r == exs_pkg::S_RUN);
  assign st_load = (state_r == exs_pkg::S_LOAD);
  assign mode1   = (intm_r == `EXS_INTM_M1);

  // Strap is caught while reset is asserted, released value sticks
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      adv_r <= (mode_s2_r == `EXS_STRAP_ADV);
    end
  end

  // Interrupt source pick: NMI, then lines low number first, then internal
  always_comb begin
    int_hit = 1'b0;
    int_num = `EXS_VN_RESET;
    if (nmi_req) begin
      int_hit = 1'b1;
      int_num = `EXS_VN_NMI;
    end else if (!i_r) begin
      if (|irq_req) begin
        int_hit = 1'b1;
        for (int k = 7; k >= 0; k--) begin
          if (irq_req[k]) begin
            int_num = `EXS_VN_IRQ + 7'(k);
          end
        end
      end else if (int_req && int_vec >= `EXS_VN_INT_LO && int_vec <= `EXS_VN_INT_HI) begin
        int_hit = 1'b1;
        int_num = int_vec;
      end
    end
  end

  // Boundary is end of an instruction or of a non-reset sequence
  assign bnd    = (st_run && insn_done) || (st_load && kind_r != exs_pkg::K_RESET);
  assign int_go = bnd && int_hit && !blk_r && !(st_run && insn_no_irq);

  always_comb begin
    go       = 1'b0;
    kind_nxt = exs_pkg::K_INT;
    num_nxt  = int_num;
    if (int_go) begin
      go = 1'b1;
    end else if (bnd && (dt_pend_r || (st_run && sleep_direct))) begin
      go       = 1'b1;
      kind_nxt = exs_pkg::K_DIRECT;
      num_nxt  = `EXS_VN_DIRECT;
    end else if (bnd && (trap_pend_r || (st_run && trap_exec))) begin
      go       = 1'b1;
      kind_nxt = exs_pkg::K_TRAP;
      num_nxt  = trap_pend_r ? tnum_r : `EXS_VN_TRAP + {5'h00, trap_num};
    end
  end

  // A trap or sleep that loses to an interrupt waits for the next boundary
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      trap_pend_r <= 1'b0;
      dt_pend_r   <= 1'b0;
      tnum_r      <= `EXS_VN_TRAP;
    end else begin
      if (st_run && insn_done && trap_exec && !(go && kind_nxt == exs_pkg::K_TRAP)) begin
        trap_pend_r <= 1'b1;
        tnum_r      <= `EXS_VN_TRAP + {5'h00, trap_num};
      end else if (go && kind_nxt == exs_pkg::K_TRAP) begin
        trap_pend_r <= 1'b0;
      end
      if (st_run && insn_done && sleep_direct && !(go && kind_nxt == exs_pkg::K_DIRECT)) begin
        dt_pend_r <= 1'b1;
      end else if (go && kind_nxt == exs_pkg::K_DIRECT) begin
        dt_pend_r <= 1'b0;
      end
    end
  end

  // First instruction after reset always runs before any interrupt
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      blk_r <= 1'b1;
    end else if (st_run && insn_done) begin
      blk_r <= 1'b0;
    end
  end

  // Normal mode keeps only the 16-bit entry, bounding PC to 64 Kbyte
  assign vec_pc = adv_r ? mem_rdata[`EXS_AW-1:0] : {8'h00, mem_rdata[15:0]};
  assign ret_pc = st_load ? pc_r : pc_in;

  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      state_r   <= exs_pkg::S_HOLD;
      kind_r    <= exs_pkg::K_RESET;
      num_r     <= `EXS_VN_RESET;
      req_r     <= 1'b0;
      push_r    <= 1'b0;
      addr_r    <= '0;
      wdata_r   <= '0;
      pc_r      <= '0;
      pc_load_r <= 1'b0;
      halt_r    <= 1'b1;
      int_ack_r <= 1'b0;
      ack_vec_r <= `EXS_VN_RESET;
    end else begin
      pc_load_r <= 1'b0;
      int_ack_r <= 1'b0;
      unique case (state_r)
        exs_pkg::S_HOLD: begin
          state_r <= exs_pkg::S_RVEC;
          req_r   <= 1'b1;
          addr_r  <= vi.addr;
        end
        exs_pkg::S_RVEC, exs_pkg::S_VEC: begin
          if (mem_ack) begin
            req_r     <= 1'b0;
            pc_r      <= vec_pc;
            pc_load_r <= 1'b1;
            state_r   <= exs_pkg::S_LOAD;
          end
        end
        exs_pkg::S_PUSH_PC: begin
          if (mem_ack) begin
            wdata_r <= {16'h0000, ccr_in};
            state_r <= exs_pkg::S_PUSH_CCR;
          end
        end
        exs_pkg::S_PUSH_CCR: begin
          if (mem_ack) begin
            push_r  <= 1'b0;
            addr_r  <= vi.addr;
            state_r <= exs_pkg::S_VEC;
          end
        end
        exs_pkg::S_LOAD, exs_pkg::S_RUN: begin
          if (go) begin
            state_r <= exs_pkg::S_PUSH_PC;
            kind_r  <= kind_nxt;
            num_r   <= num_nxt;
            req_r   <= 1'b1;
            push_r  <= 1'b1;
            wdata_r <= ret_pc;
            halt_r  <= 1'b1;
            if (int_go) begin
              int_ack_r <= 1'b1;
              ack_vec_r <= num_nxt;
            end
          end else begin
            state_r <= exs_pkg::S_RUN;
            halt_r  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Mask bits: hardware set wins over a software write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      i_r  <= 1'b1;
      ui_r <= 1'b0;
    end else if (go) begin
      i_r <= 1'b1;
      if (mode1) begin
        ui_r <= 1'b1;
      end
    end else if (reg_wr && reg_addr == `EXS_REG_CCR) begin
      i_r  <= reg_wdata[`EXS_CCR_I];
      ui_r <= reg_wdata[`EXS_CCR_UI];
    end
  end

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      intm_r  <= 2'h0;
      mstop_r <= `EXS_MSTOP_RST;
      prst_r  <= 1'b1;
    end else begin
      prst_r <= 1'b0;
      if (reg_wr && reg_addr == `EXS_REG_SYS) begin
        intm_r <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == `EXS_REG_MSTOP) begin
        mstop_r <= reg_wdata;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (int_rst || !reg_rd) begin
      rdata_r <= '0;
    end else begin
      unique case (reg_addr)
        `EXS_REG_SYS:   rdata_r <= {14'h0000, intm_r};
        `EXS_REG_MSTOP: rdata_r <= mstop_r;
        `EXS_REG_CCR:   rdata_r <= {8'h00, i_r, ui_r, 6'h00};
        `EXS_REG_STAT:  rdata_r <= {state_r, adv_r, blk_r, 4'h0, num_r};
      endcase
    end
  end

  assign reg_rdata  = rdata_r;
  assign cpu_halt   = halt_r;
  assign periph_rst = prst_r;
  assign pc_load    = pc_load_r;
  assign pc_value   = pc_r;
  assign mem_req    = req_r;
  assign mem_push   = push_r;
  assign mem_addr   = addr_r;
  assign mem_wdata  = wdata_r;
  assign int_ack    = int_ack_r;
  assign ack_vec    = ack_vec_r;
  assign i_mask     = i_r;
  assign ui_mask    = ui_r;
  assign mstop      = mstop_r;
  assign adv_mode   = adv_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  halt_in_reset_a: assert property (int_rst |=> cpu_halt && state_r == exs_pkg::S_HOLD)
    else $error("not halted in reset");
  reset_vec_addr_a: assert property (state_r == exs_pkg::S_RVEC && req_r |-> addr_r == '0 && !push_r)
    else $error("reset vector address wrong");
  reset_load_a: assert property (state_r == exs_pkg::S_RVEC && mem_ack && !int_rst |=> pc_load && i_mask)
    else $error("reset vector not loaded");
  first_insn_a: assert property (blk_r |=> !int_ack)
    else $error("interrupt taken before first insn");
  no_detect_a: assert property (st_run && insn_done && insn_no_irq |-> !int_go)
    else $error("interrupt after flag insn");
  trap_vec_a: assert property (go && kind_nxt == exs_pkg::K_TRAP && !trap_pend_r && !int_rst
    |=> num_r == `EXS_VN_TRAP + {5'h00, $past(trap_num)}) else $error("trap vector wrong");
  mask_set_a: assert property (go && !int_rst |=> i_mask ##0 (ui_mask || !$past(mode1)))
    else $error("mask bits not set");
  ui_keep_a: assert property (go && !mode1 && !int_rst |=> ui_mask == $past(ui_mask))
    else $error("ui changed in mode 0");
  nmi_first_a: assert property (int_go && nmi_req && !int_rst |=> num_r == `EXS_VN_NMI)
    else $error("nmi not first");
  push_order_a: assert property (state_r == exs_pkg::S_PUSH_PC && mem_ack && !int_rst
    |=> state_r == exs_pkg::S_PUSH_CCR && mem_push && mem_req) else $error("push order wrong");
  mstop_init_a: assert property ($fell(int_rst) |-> mstop == `EXS_MSTOP_RST)
    else $error("module stop not set");
endmodule : exs_sequencer

// [logic/exs_vec_gen.sv]
// Purpose: Vector table address generator
// Assumes: Table starts at address zero
// Notes:   Two-byte entries in normal mode, four in advanced
`timescale 1ns/1ps
`include "exs_cfg.svh"
module exs_vec_gen (
  exs_vec_if.gen vi
);
  logic [`EXS_AW-1:0] num_w;
  assign num_w   = {{(`EXS_AW-`EXS_VNW){1'b0}}, vi.num};
  assign vi.addr = vi.adv ? (num_w << 2) : (num_w << 1);
endmodule : exs_vec_gen

// [logic/exs_vec_if.sv]
// Purpose: Vector number to table address link
// Assumes: Single clock
// Notes:   Carries the address mode beside the number
`timescale 1ns/1ps
`include "exs_cfg.svh"
interface exs_vec_if;
  logic [`EXS_VNW-1:0] num;
  logic                adv;
  logic [`EXS_AW-1:0]  addr;
  modport gen (input num, input adv, output addr);
  modport use_p (output num, output adv, input addr);
endinterface : exs_vec_if

// [test/exs_mem_model.sv]
// Purpose: Vector memory and stack side model for the exception sequencer
// Assumes: One transfer at a time, single clock
// Notes:   Vector words derive from the address so the bench can predict them
`timescale 1ns/1ps
module exs_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [1:0]  wait_r;
  logic [31:0] word;
  assign word = {8'hc3, 8'h12, mem_addr[15:0] + 16'h1000};
  // Outside the ack the data is inverted, so a late or early read shows up
  assign mem_rdata = mem_ack ? word : ~word;
  always @(posedge sys_clk) begin
    if (rst || !mem_req || mem_ack) begin
      mem_ack <= 1'b0;
      wait_r  <= slow ? 2'h3 : 2'h0;
    end else if (wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else begin
      mem_ack <= 1'b1;
    end
  end
endmodule : exs_mem_model

// [test/tb_exs_sequencer.sv]
// Purpose: Self-checking bench for the exception sequencer
// Assumes: Memory model acks every transfer, prompt or slow
// Notes:   Requests are dropped by the bench when the sequencer acks them
`timescale 1ns/1ps
module tb_exs_sequencer;
  logic        sys_clk = 0, rst = 1, pin_n = 1, mode_pin = 1, wdt = 0, nmi = 0, int_req = 0;
  logic        done = 0, no_irq = 0, sleep = 0, trap = 0, slow = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0]  irq = 0;
  logic [1:0]  tnum = 0, reg_addr = 0;
  logic [15:0] reg_wdata = 0, rd, reg_rdata, mstop;
  logic [23:0] pc_in = 24'h00abc0, pc_value, mem_addr, mem_wdata, rd_addr;
  logic [31:0] mem_rdata;
  logic [6:0]  ack_vec, last_ack;
  logic        mem_ack, cpu_halt, periph_rst, pc_load, mem_req, mem_push, int_ack, i_mask, ui_mask, adv_mode;
  logic [23:0] pushes[$];
  int          fails = 0, num_checks = 0, pcs = 0, acks = 0, n0;

  always #20 sys_clk = ~sys_clk;

  exs_sequencer i_exs_sequencer (.sys_clk(sys_clk), .rst(rst), .external_reset_pin_n(pin_n),
    .mode_sel_pin(mode_pin), .wdt_overflow(wdt), .nmi_req(nmi), .irq_req(irq), .int_req(int_req),
    .int_vec(7'h18), .insn_done(done), .insn_no_irq(no_irq), .sleep_direct(sleep), .trap_exec(trap),
    .trap_num(tnum), .pc_in(pc_in), .ccr_in(8'h3c), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_halt(cpu_halt), .periph_rst(periph_rst), .pc_load(pc_load), .pc_value(pc_value),
    .mem_req(mem_req), .mem_push(mem_push), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .int_ack(int_ack), .ack_vec(ack_vec), .i_mask(i_mask), .ui_mask(ui_mask), .mstop(mstop),
    .adv_mode(adv_mode));

  exs_mem_model i_exs_mem_model (.sys_clk(sys_clk), .rst(rst), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Interrupt controller stand-in: drops its request once acknowledged
  always @(posedge sys_clk) begin
    if (mem_req && mem_ack) begin
      if (mem_push) pushes.push_back(mem_wdata);
      else rd_addr <= mem_addr;
    end
    if (pc_load) pcs <= pcs + 1;
    if (int_ack) begin
      acks     <= acks + 1;
      last_ack <= ack_vec;
      nmi      <= 1'b0;
      irq      <= 8'h00;
      int_req  <= 1'b0;
    end
  end

  task check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  function logic [23:0] vaddr(input logic [6:0] vn);
    return !mode_pin ? {15'h0, vn, 2'h0} : {16'h0, vn, 1'b0};
  endfunction : vaddr

  task wreg(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wreg

  task rreg(input logic [1:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rreg

  task wait_pc(input int n);
    int k;
    k = 0;
    while (pcs < n && k < 400) begin
      @(posedge sys_clk);
      #1 k++;
    end
    check(24'(pcs), 24'(n));
  endtask : wait_pc

  // Issues one completed instruction once the pipeline is free to run
  task insn(input logic ni, input logic sl, input logic tr, input logic [1:0] tn);
    int k;
    k = 0;
    while (cpu_halt !== 1'b0 && k < 400) begin
      @(posedge sys_clk);
      #1 k++;
    end
    check(24'(cpu_halt), 24'h0);
    @(posedge sys_clk);
    {done, no_irq, sleep, trap, tnum} <= {1'b1, ni, sl, tr, tn};
    @(posedge sys_clk);
    {done, no_irq, sleep, trap} <= 4'h0;
  endtask : insn

  task pc_chk(input logic [6:0] vn);
    logic [23:0] a;
    a = vaddr(vn);
    check(rd_addr, a);
    check(pc_value & (!mode_pin ? 24'hffffff : 24'h00ffff), {!mode_pin ? 8'h12 : 8'h00, 16'h1000 + a[15:0]});
  endtask : pc_chk

  task exc(input logic sl, input logic tr, input logic [1:0] tn, input logic [6:0] vn);
    n0 = pcs;
    pushes.delete();
    insn(1'b0, sl, tr, tn);
    wait_pc(n0 + 1);
    pc_chk(vn);
    check(24'(pushes.size()), 24'h2);
    check(pushes[0], pc_in);
    check(pushes[1], 24'h00003c);
    check(i_mask, 1'b1);
  endtask : exc

  initial begin
    #(40 * 30000);
    fails++;
    tally_and_finish();
  end

  initial begin
    nmi = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    wait_pc(1);
    pc_chk(7'h00);
    check(i_mask, 1'b1);
    check(adv_mode, 1'b0);
    check(periph_rst, 1'b0);
    rreg(2'h1, rd);
    check(rd, 16'hffff);
    // First instruction completes with NMI pending: still no acceptance
    insn(1'b0, 1'b0, 1'b0, 2'h0);
    repeat (8) @(posedge sys_clk);
    check(24'(acks), 24'h0);
    exc(1'b0, 1'b0, 2'h0, 7'h07);
    check(last_ack, 7'h07);
    for (int n = 0; n < 4; n++) begin
      slow <= n[1];
      wreg(2'h0, 16'(n[0]));
      wreg(2'h2, n == 2 ? 16'h00c0 : 16'h0000);
      exc(1'b0, 1'b1, 2'(n), 7'(8 + n));
      check(ui_mask, n[0] | (n == 2));
    end
    wreg(2'h0, 16'h0000);
    wreg(2'h1, 16'h0000);
    wreg(2'h2, 16'h0000);
    irq <= 8'h08;
    n0 = pcs;
    insn(1'b1, 1'b0, 1'b0, 2'h0);
    repeat (10) @(posedge sys_clk);
    check(24'(pcs), 24'(n0));
    exc(1'b0, 1'b0, 2'h0, 7'h13);
    wreg(2'h2, 16'h0000);
    int_req <= 1'b1;
    exc(1'b0, 1'b0, 2'h0, 7'h18);
    exc(1'b1, 1'b0, 2'h0, 7'h06);
    nmi <= 1'b1;
    n0 = pcs;
    insn(1'b0, 1'b0, 1'b1, 2'h3);
    wait_pc(n0 + 2);
    check(last_ack, 7'h07);
    pc_chk(7'h0b);
    @(posedge sys_clk);
    mode_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    wdt <= 1'b1;
    @(posedge sys_clk);
    wdt <= 1'b0;
    n0 = pcs;
    wait_pc(n0 + 1);
    pc_chk(7'h00);
    check(mstop, 24'h00ffff);
    check(adv_mode, 1'b1);
    exc(1'b0, 1'b1, 2'h2, 7'h0a);
    @(posedge sys_clk);
    pin_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check(cpu_halt, 1'b1);
    check(periph_rst, 1'b1);
    n0 = pcs;
    pin_n <= 1'b1;
    wait_pc(n0 + 1);
    pc_chk(7'h00);
    tally_and_finish();
  end
endmodule : tb_exs_sequencer
